// ===== design/dpm_pkg.sv
package dpm_pkg;
  localparam int DPM_AW_MAX = 18;
  localparam int DPM_DW = 36;
  localparam int DPM_LANES = 4;
  localparam int DPM_LANE_W = 9;
  localparam int DPM_NPORT = 2;
  localparam int DPM_PORT_L = 0;
  localparam int DPM_PORT_R = 1;
  localparam logic DPM_RW_WRITE = 1'h0;
  localparam logic DPM_FLAG_IDLE = 1'h1;
  localparam logic [DPM_LANES-1:0] DPM_LANES_NONE_N = 4'hF;
  localparam logic [DPM_AW_MAX-1:0] DPM_CNT_CLEAR = 18'h00000;

  typedef struct packed {
    logic sel_low_n;
    logic sel_high;
    logic rw;
    logic [DPM_LANES-1:0] lanes_n;
    logic [DPM_AW_MAX-1:0] addr;
    logic [DPM_DW-1:0] wdata;
  } dpm_req_t;

  typedef struct packed {
    logic [DPM_DW-1:0] rdata;
    logic rvalid;
  } dpm_rsp_t;
endpackage : dpm_pkg

// ===== design/dpm_mailbox.sv
`timescale 1ns/10ps
module dpm_mailbox import dpm_pkg::*; #(
  parameter int ADDR_W = DPM_AW_MAX
) (
  input wire logic CORE_CLK_I,
  input wire logic SRST_I,
  input wire logic MASTER_CLEAR_N_I,
  input wire logic L_SELECT_LOW_ACTIVE_N_I,
  input wire logic L_SELECT_HIGH_ACTIVE_I,
  input wire logic L_RW_I,
  input wire logic [DPM_LANES-1:0] L_BYTE_LANE_SELECTS_N_I,
  input wire logic [DPM_AW_MAX-1:0] L_ADDR_I,
  input wire logic [DPM_DW-1:0] L_WDATA_I,
  input wire logic R_SELECT_LOW_ACTIVE_N_I,
  input wire logic R_SELECT_HIGH_ACTIVE_I,
  input wire logic R_RW_I,
  input wire logic [DPM_LANES-1:0] R_BYTE_LANE_SELECTS_N_I,
  input wire logic [DPM_AW_MAX-1:0] R_ADDR_I,
  input wire logic [DPM_DW-1:0] R_WDATA_I,
  output logic L_MAILBOX_FLAG_N_O,
  output logic R_MAILBOX_FLAG_N_O,
  output logic L_COUNTER_WRAP_FLAG_N_O,
  output logic R_COUNTER_WRAP_FLAG_N_O,
  output logic [DPM_AW_MAX-1:0] L_COUNTER_O,
  output logic [DPM_AW_MAX-1:0] R_COUNTER_O,
  output logic [DPM_AW_MAX-1:0] L_MASK_O,
  output logic [DPM_AW_MAX-1:0] R_MASK_O,
  output logic [DPM_DW-1:0] L_RDATA_O,
  output logic L_RVALID_O,
  output logic [DPM_DW-1:0] R_RDATA_O,
  output logic R_RVALID_O
);
  // Only the low ADDR_W bits decode; the top word of that space is the right mailbox
  localparam logic [DPM_AW_MAX-1:0] ADDR_MASK = DPM_AW_MAX'((64'h1 << ADDR_W) - 64'h1);
  localparam logic [DPM_AW_MAX-1:0] MBOX_R = ADDR_MASK;
  localparam logic [DPM_AW_MAX-1:0] MBOX_L = ADDR_MASK - 18'h00001;

  dpm_req_t req_in [DPM_NPORT];
  dpm_req_t s1_r [DPM_NPORT];
  dpm_req_t s1_nxt [DPM_NPORT];
  dpm_req_t s2_r [DPM_NPORT];
  dpm_req_t s2_nxt [DPM_NPORT];
  logic mclr_s1_r, mclr_s1_nxt, mclr_s2_r, mclr_s2_nxt;
  logic mclr_now;
  logic [DPM_AW_MAX-1:0] mbox_addr [DPM_NPORT];
  logic [DPM_NPORT-1:0] sel, wr, rd;
  logic [DPM_NPORT-1:0] hit [DPM_NPORT];
  logic [DPM_NPORT-1:0] set, clr;
  logic [DPM_NPORT-1:0] flag_r, flag_nxt, wrap_r, wrap_nxt;
  logic [DPM_AW_MAX-1:0] cnt_r [DPM_NPORT];
  logic [DPM_AW_MAX-1:0] cnt_nxt [DPM_NPORT];
  logic [DPM_AW_MAX-1:0] mask_r [DPM_NPORT];
  logic [DPM_AW_MAX-1:0] mask_nxt [DPM_NPORT];
  logic [DPM_DW-1:0] mem_r [DPM_NPORT];
  logic [DPM_DW-1:0] mem_nxt [DPM_NPORT];
  dpm_rsp_t rsp_r [DPM_NPORT];
  dpm_rsp_t rsp_nxt [DPM_NPORT];

  assign req_in[DPM_PORT_L] = '{L_SELECT_LOW_ACTIVE_N_I, L_SELECT_HIGH_ACTIVE_I, L_RW_I,
                                L_BYTE_LANE_SELECTS_N_I, L_ADDR_I, L_WDATA_I};
  assign req_in[DPM_PORT_R] = '{R_SELECT_LOW_ACTIVE_N_I, R_SELECT_HIGH_ACTIVE_I, R_RW_I,
                                R_BYTE_LANE_SELECTS_N_I, R_ADDR_I, R_WDATA_I};
  assign mbox_addr[DPM_PORT_L] = MBOX_L;
  assign mbox_addr[DPM_PORT_R] = MBOX_R;

  // Pin synchronisers; master clear is sampled through two flops like the pins and acts on both ports at once
  always_comb begin
    s1_nxt = req_in;
    s2_nxt = s1_r;
    mclr_s1_nxt = MASTER_CLEAR_N_I;
    mclr_s2_nxt = mclr_s1_r;
  end

  always_ff @(posedge CORE_CLK_I) begin
    if (SRST_I) begin
      for (int p = 0; p < DPM_NPORT; p++) begin
        s1_r[p] <= '{1'h1, 1'h0, 1'h1, DPM_LANES_NONE_N, DPM_CNT_CLEAR, 36'h000000000};
        s2_r[p] <= '{1'h1, 1'h0, 1'h1, DPM_LANES_NONE_N, DPM_CNT_CLEAR, 36'h000000000};
      end
      mclr_s1_r <= 1'h1;
      mclr_s2_r <= 1'h1;
    end else begin
      s1_r <= s1_nxt;
      s2_r <= s2_nxt;
      mclr_s1_r <= mclr_s1_nxt;
      mclr_s2_r <= mclr_s2_nxt;
    end
  end

  assign mclr_now = !mclr_s2_r;

  // Access decode; output enable is not an input here, so it cannot touch the flags
  always_comb begin
    for (int p = 0; p < DPM_NPORT; p++) begin
      sel[p] = !s2_r[p].sel_low_n && s2_r[p].sel_high;
      wr[p] = sel[p] && (s2_r[p].lanes_n != DPM_LANES_NONE_N) && (s2_r[p].rw == DPM_RW_WRITE);
      rd[p] = sel[p] && (s2_r[p].lanes_n != DPM_LANES_NONE_N) && (s2_r[p].rw != DPM_RW_WRITE);
      for (int m = 0; m < DPM_NPORT; m++) begin
        hit[p][m] = (s2_r[p].addr & ADDR_MASK) == mbox_addr[m];
      end
    end
    for (int p = 0; p < DPM_NPORT; p++) begin
      set[p] = wr[1-p] && hit[1-p][p];
      clr[p] = rd[p] && hit[p][p];
    end
  end

  always_comb begin
    for (int p = 0; p < DPM_NPORT; p++) begin
      flag_nxt[p] = flag_r[p];
      if (clr[p]) begin
        flag_nxt[p] = DPM_FLAG_IDLE;
      end
      // A set in the same edge as the owner's read wins
      if (set[p]) begin
        flag_nxt[p] = !DPM_FLAG_IDLE;
      end
      wrap_nxt[p] = wrap_r[p];
      cnt_nxt[p] = cnt_r[p];
      mask_nxt[p] = mask_r[p];
      if (mclr_now) begin
        flag_nxt[p] = DPM_FLAG_IDLE;
        wrap_nxt[p] = DPM_FLAG_IDLE;
        cnt_nxt[p] = DPM_CNT_CLEAR;
        mask_nxt[p] = ADDR_MASK;
      end
    end
  end

  // Mailbox storage; a same-edge write to one word by both ports leaves the right port's bytes
  always_comb begin
    mem_nxt = mem_r;
    for (int p = 0; p < DPM_NPORT; p++) begin
      for (int m = 0; m < DPM_NPORT; m++) begin
        if (wr[p] && hit[p][m]) begin
          for (int k = 0; k < DPM_LANES; k++) begin
            if (!s2_r[p].lanes_n[k]) begin
              mem_nxt[m][k*DPM_LANE_W +: DPM_LANE_W] = s2_r[p].wdata[k*DPM_LANE_W +: DPM_LANE_W];
            end
          end
        end
      end
    end
    for (int p = 0; p < DPM_NPORT; p++) begin
      rsp_nxt[p].rvalid = rd[p] && (hit[p] != 2'h0);
      rsp_nxt[p].rdata = 36'h000000000;
      for (int m = 0; m < DPM_NPORT; m++) begin
        if (rd[p] && hit[p][m]) begin
          for (int k = 0; k < DPM_LANES; k++) begin
            if (!s2_r[p].lanes_n[k]) begin
              rsp_nxt[p].rdata[k*DPM_LANE_W +: DPM_LANE_W] = mem_r[m][k*DPM_LANE_W +: DPM_LANE_W];
            end
          end
        end
      end
    end
  end

  always_ff @(posedge CORE_CLK_I) begin
    if (SRST_I) begin
      flag_r <= {DPM_NPORT{DPM_FLAG_IDLE}};
      wrap_r <= {DPM_NPORT{DPM_FLAG_IDLE}};
      for (int p = 0; p < DPM_NPORT; p++) begin
        cnt_r[p] <= DPM_CNT_CLEAR;
        mask_r[p] <= ADDR_MASK;
        mem_r[p] <= 36'h000000000;
        rsp_r[p] <= '{36'h000000000, 1'h0};
      end
    end else begin
      flag_r <= flag_nxt;
      wrap_r <= wrap_nxt;
      cnt_r <= cnt_nxt;
      mask_r <= mask_nxt;
      mem_r <= mem_nxt;
      rsp_r <= rsp_nxt;
    end
  end

  assign L_MAILBOX_FLAG_N_O = flag_r[DPM_PORT_L];
  assign R_MAILBOX_FLAG_N_O = flag_r[DPM_PORT_R];
  assign L_COUNTER_WRAP_FLAG_N_O = wrap_r[DPM_PORT_L];
  assign R_COUNTER_WRAP_FLAG_N_O = wrap_r[DPM_PORT_R];
  assign L_COUNTER_O = cnt_r[DPM_PORT_L];
  assign R_COUNTER_O = cnt_r[DPM_PORT_R];
  assign L_MASK_O = mask_r[DPM_PORT_L];
  assign R_MASK_O = mask_r[DPM_PORT_R];
  assign L_RDATA_O = rsp_r[DPM_PORT_L].rdata;
  assign L_RVALID_O = rsp_r[DPM_PORT_L].rvalid;
  assign R_RDATA_O = rsp_r[DPM_PORT_R].rdata;
  assign R_RVALID_O = rsp_r[DPM_PORT_R].rvalid;

  default clocking cb @(posedge CORE_CLK_I); endclocking
  default disable iff (SRST_I);

  sequence s_full_wr_l_to_r;
    wr[0] && hit[0][1] && (s2_r[0].lanes_n == 4'h0) && !(wr[1] && hit[1][1]);
  endsequence
  sequence s_full_rd_r_own;
    rd[1] && hit[1][1] && (s2_r[1].lanes_n == 4'h0);
  endsequence

  AST_SET_L: assert property (wr[1] && hit[1][0] && !mclr_now |=> !L_MAILBOX_FLAG_N_O)
    else $error("Right write to left mailbox did not assert left flag");
  AST_SET_R: assert property (wr[0] && hit[0][1] && !mclr_now |=> !R_MAILBOX_FLAG_N_O)
    else $error("Left write to right mailbox did not assert right flag");
  AST_CLR_L: assert property (rd[0] && hit[0][0] && !set[0] |=> L_MAILBOX_FLAG_N_O)
    else $error("Left own mailbox read did not release left flag");
  AST_CLR_R: assert property (rd[1] && hit[1][1] && !set[1] |=> R_MAILBOX_FLAG_N_O)
    else $error("Right own mailbox read did not release right flag");
  AST_CAUSE_L: assert property ($changed(L_MAILBOX_FLAG_N_O) |-> $past(set[0] || clr[0] || mclr_now))
    else $error("Left flag changed without a qualified access");
  AST_CAUSE_R: assert property ($changed(R_MAILBOX_FLAG_N_O) |->
    $past(wr[0] && hit[0][1] && sel[0]) || $past(rd[1] && hit[1][1]) || $past(mclr_now))
    else $error("Right flag changed without a qualified access");
  AST_MCLR: assert property (mclr_now |=> {L_MAILBOX_FLAG_N_O, R_MAILBOX_FLAG_N_O, L_COUNTER_WRAP_FLAG_N_O,
    R_COUNTER_WRAP_FLAG_N_O} == 4'hF && L_COUNTER_O == 18'h00000 && R_MASK_O == ADDR_MASK)
    else $error("Master clear left state not at its cleared values");
  AST_DATA: assert property (s_full_wr_l_to_r ##1 s_full_rd_r_own |=>
    R_RVALID_O && R_RDATA_O == $past(s2_r[0].wdata, 2))
    else $error("Right mailbox read did not return last written word");
endmodule : dpm_mailbox

// ===== testbench/dpm_host.sv
`timescale 1ns/10ps
module dpm_host import dpm_pkg::*; (
  input wire logic clk_i,
  input wire logic [DPM_DW-1:0] rdata_i,
  input wire logic rvalid_i,
  output dpm_req_t req_o
);
  logic [DPM_DW-1:0] rd_q;
  logic rv_q;
  initial req_o = '{1'h1, 1'h0, 1'h1, 4'hF, 18'h00000, 36'h000000000};
  // One access: held across the sampling edge, released at the next falling edge, answer taken 2 edges on
  task automatic access(input logic sel, input logic rw, input logic [3:0] ln, input logic [17:0] a,
                        input logic [35:0] d);
    @(negedge clk_i);
    req_o = '{~sel, sel, rw, ln, a, d};
    @(posedge clk_i);
    @(negedge clk_i);
    // Released rw, address and data lines show the inverse so a stale value cannot pass; selects and lanes go idle
    req_o = '{1'h1, 1'h0, ~req_o.rw, 4'hF, ~req_o.addr, ~req_o.wdata};
    repeat (2) @(posedge clk_i);
    #1;
    rd_q = rdata_i;
    rv_q = rvalid_i;
  endtask : access
endmodule : dpm_host

// ===== testbench/dual_port_mailbox_reset_tb.sv
`timescale 1ns/10ps
module dual_port_mailbox_reset_tb import dpm_pkg::*;;
  localparam int AW = 16;
  localparam logic [17:0] MB_R = 18'h0FFFF;
  localparam logic [17:0] MB_L = 18'h0FFFE;
  localparam logic [35:0] D1 = 36'h9A5C3E1F7;
  localparam logic [35:0] D2 = 36'h3C2B1D4E5;
  logic clk = 1'h0;
  logic srst = 1'h1;
  logic mclr_n = 1'h1;
  dpm_req_t rq_l;
  dpm_req_t rq_r;
  logic lf, rf, lw, rw_f, lrv, rrv;
  logic [17:0] lc, rc, lm, rm;
  logic [35:0] lrd, rrd;
  int err_count = 0;
  int total_checks = 0;
  initial forever #2 clk = ~clk;
  dpm_host host_l (.clk_i(clk), .rdata_i(lrd), .rvalid_i(lrv), .req_o(rq_l));
  dpm_host host_r (.clk_i(clk), .rdata_i(rrd), .rvalid_i(rrv), .req_o(rq_r));
  dpm_mailbox #(.ADDR_W(AW)) dut (.CORE_CLK_I(clk), .SRST_I(srst), .MASTER_CLEAR_N_I(mclr_n),
    .L_SELECT_LOW_ACTIVE_N_I(rq_l.sel_low_n), .L_SELECT_HIGH_ACTIVE_I(rq_l.sel_high), .L_RW_I(rq_l.rw),
    .L_BYTE_LANE_SELECTS_N_I(rq_l.lanes_n), .L_ADDR_I(rq_l.addr), .L_WDATA_I(rq_l.wdata),
    .R_SELECT_LOW_ACTIVE_N_I(rq_r.sel_low_n), .R_SELECT_HIGH_ACTIVE_I(rq_r.sel_high), .R_RW_I(rq_r.rw),
    .R_BYTE_LANE_SELECTS_N_I(rq_r.lanes_n), .R_ADDR_I(rq_r.addr), .R_WDATA_I(rq_r.wdata),
    .L_MAILBOX_FLAG_N_O(lf), .R_MAILBOX_FLAG_N_O(rf), .L_COUNTER_WRAP_FLAG_N_O(lw),
    .R_COUNTER_WRAP_FLAG_N_O(rw_f), .L_COUNTER_O(lc), .R_COUNTER_O(rc), .L_MASK_O(lm), .R_MASK_O(rm),
    .L_RDATA_O(lrd), .L_RVALID_O(lrv), .R_RDATA_O(rrd), .R_RVALID_O(rrv));
  task automatic chk(input string nm, input logic [35:0] ex, input logic [35:0] got);
    total_checks++;
    if (ex !== got) begin
      err_count++;
      $display("mismatch %s exp %h got %h", nm, ex, got);
    end
  endtask : chk
  task automatic close_out;
    $display("checks %0d errors %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : close_out
  task automatic mclr_pulse;
    @(negedge clk);
    mclr_n = 1'h0;
    repeat (2) @(negedge clk);
    mclr_n = 1'h1;
    repeat (3) @(posedge clk);
    #1;
  endtask : mclr_pulse
  task automatic t_clear_state;
    chk("flags", 36'h3, 36'({lf, rf}));
    chk("wrap", 36'h3, 36'({lw, rw_f}));
    chk("counters", 36'h0, {lc, rc});
    chk("masks", {18'h0FFFF, 18'h0FFFF}, {lm, rm});
  endtask : t_clear_state
  // Left writes the right mailbox: no lanes, deselected, then one lane
  task automatic t_set;
    host_l.access(1'h1, DPM_RW_WRITE, 4'hF, MB_R, D1);
    chk("rflag_nolane", 36'h1, 36'(rf));
    host_l.access(1'h0, DPM_RW_WRITE, 4'h0, MB_R, D1);
    chk("rflag_desel", 36'h1, 36'(rf));
    host_l.access(1'h1, DPM_RW_WRITE, 4'hE, MB_R, D1);
    chk("rflag_set", 36'h0, 36'(rf));
  endtask : t_set
  // Reads of the other mailbox and writes of one's own leave flags alone
  task automatic t_other;
    host_l.access(1'h1, 1'h1, 4'h0, MB_R, 36'h0);
    chk("rflag_peek", 36'h0, 36'(rf));
    chk("l_rvalid", 36'h1, 36'(host_l.rv_q));
    chk("l_rdata", {27'h0, D1[8:0]}, host_l.rd_q);
    host_r.access(1'h1, DPM_RW_WRITE, 4'h0, MB_R, D2);
    chk("lflag_own", 36'h1, 36'(lf));
    chk("rflag_own", 36'h0, 36'(rf));
  endtask : t_other
  // Owner reads its mailbox: no lanes first, then two lanes
  task automatic t_owner;
    host_r.access(1'h1, 1'h1, 4'hF, MB_R, 36'h0);
    chk("rflag_nolane_rd", 36'h0, 36'(rf));
    host_r.access(1'h1, 1'h1, 4'hC, MB_R, 36'h0);
    chk("rflag_clr", 36'h1, 36'(rf));
    chk("r_rdata", {18'h0, D2[17:0]}, host_r.rd_q);
    chk("r_rvalid", 36'h1, 36'(host_r.rv_q));
    @(posedge clk);
    #1;
    chk("r_rvalid_drop", 36'h0, 36'(rrv));
  endtask : t_owner
  // Left fills the right mailbox while the right port reads it one cycle later
  task automatic t_flow;
    fork
      begin
        host_l.access(1'h1, DPM_RW_WRITE, 4'h0, MB_R, D1);
        chk("rflag_flow_set", 36'h0, 36'(rf));
      end
      begin
        @(negedge clk);
        host_r.access(1'h1, 1'h1, 4'h0, MB_R, 36'h0);
      end
    join
    chk("rflag_flow_clr", 36'h1, 36'(rf));
    chk("r_rdata_flow", D1, host_r.rd_q);
  endtask : t_flow
  // Right sets the left flag, left reads it back, right sets it again, master clear returns it high
  task automatic t_mclr;
    host_r.access(1'h1, DPM_RW_WRITE, 4'h7, MB_L, D1);
    chk("lflag_set", 36'h0, 36'(lf));
    host_l.access(1'h1, 1'h1, 4'h7, MB_L, 36'h0);
    chk("lflag_clr", 36'h1, 36'(lf));
    chk("l_rdata_own", {D1[35:27], 27'h0}, host_l.rd_q);
    host_r.access(1'h1, DPM_RW_WRITE, 4'h7, MB_L, D1);
    chk("lflag_reset", 36'h0, 36'(lf));
    mclr_pulse();
    t_clear_state();
  endtask : t_mclr
  initial begin
    repeat (12) @(posedge clk);
    @(negedge clk);
    srst = 1'h0;
    mclr_pulse();
    t_clear_state();
    t_set();
    t_other();
    t_owner();
    t_flow();
    t_mclr();
    close_out();
  end
  initial begin
    #20000;
    err_count++;
    close_out();
  end
endmodule : dual_port_mailbox_reset_tb
